//--- rtl/isac_pkg.sv
// Package: constants and carrier types for the inventory slot sequencer
package isac_pkg;
  // Clock and timing
  localparam int CLK_MHZ            = 200;
  localparam int RESP_DELAY_MIN_NS  = 318600;
  localparam int RESP_DELAY_NOM_NS  = 320900;
  localparam int RESP_DELAY_MAX_NS  = 323300;
  localparam int TOL_CARRIER        = 32;
  localparam int CARRIER_KHZ        = 13560;
  localparam int TOL_NS             = (TOL_CARRIER * 1000000) / CARRIER_KHZ;
  localparam int RESP_DELAY_CYC     = (RESP_DELAY_NOM_NS * CLK_MHZ) / 1000;
  localparam int TOL_CYC            = (TOL_NS * CLK_MHZ) / 1000;
  localparam int TAG_SOF_HI_NS      = 75520;
  localparam int TAG_SOF_LO_NS      = 302080;
  localparam int TAG_SOF_HI_CYC     = (TAG_SOF_HI_NS * CLK_MHZ) / 1000;
  localparam int TAG_SOF_LO_CYC     = (TAG_SOF_LO_NS * CLK_MHZ) / 1000;
  localparam int CNT_W              = 17;

  // Slot geometry
  localparam int SLOTS_MULTI        = 16;
  localparam int SLOTS_SINGLE       = 1;
  localparam int SLOT_W_MULTI       = 4;
  localparam int UID_W              = 64;
  localparam int MASK_W             = 64;
  localparam int MLEN_W             = 8;

  // Link event codes
  localparam logic [1:0] EV_NONE    = 2'h0;
  localparam logic [1:0] EV_SOF     = 2'h1;
  localparam logic [1:0] EV_EOF     = 2'h2;

  // APB map
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_UID_LO  = 8'h08;
  localparam logic [7:0] ADDR_UID_HI  = 8'h0C;
  localparam logic [7:0] ADDR_IDENT   = 8'h10;
  localparam logic [31:0] IDENT_VALUE = 32'h0000A5C3; // arbitrary value
  localparam int CTRL_HIGH_RATE     = 0;
  localparam int CTRL_QUIET         = 1;
  localparam int CTRL_ARMED         = 2;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;

  // Decoded inventory request from the front end
  typedef struct packed {
    logic                 single_slot_select;
    logic                 family_field_present;
    logic [7:0]           application_family_id;
    logic                 initiated;
    logic                 fast;
    logic                 crc_error;
    logic [MLEN_W-1:0]    mask_len;
    logic [MASK_W-1:0]    mask;
  } isac_req_t;

  // Reply launch request to the transmitter
  typedef struct packed {
    logic       start;
    logic       fast;
    logic       high_rate;
  } isac_reply_t;
endpackage : isac_pkg

//--- rtl/isac_sync.sv
// Two-flop synchroniser with rising-edge detect on the second stage
`timescale 1ns/1ps
module isac_sync (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic SYS_RST,
  // Async in, synced out
  input  wire logic din,
  output logic      dout,
  output logic      rise
);
  logic s1;
  logic s2;
  logic s3;
  logic next_s1;
  logic next_s2;
  logic next_s3;

  always_comb begin
    next_s1 = din;
    next_s2 = s1;
    next_s3 = s2;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  assign dout = s2;
  assign rise = s2 & ~s3;
endmodule : isac_sync

//--- rtl/isac_match.sv
// Slot match: low UID bits against slot index above the mask
`timescale 1ns/1ps
module isac_match
  import isac_pkg::*;
(
  // Operands
  input  wire logic [UID_W-1:0]  uid,
  input  wire logic [MASK_W-1:0] mask,
  input  wire logic [MLEN_W-1:0] mask_len,
  input  wire logic [3:0]        slot_index,
  input  wire logic [2:0]        slot_index_width,
  // Result
  output logic                   hit
);
  logic [UID_W-1:0] ref_val;
  logic [UID_W-1:0] cmp_mask;
  logic [7:0]       total;
  logic [UID_W-1:0] ones;
  logic [UID_W-1:0] mmask;

  always_comb begin
    ones     = {UID_W{1'b1}};
    total    = mask_len + {5'h00, slot_index_width};
    mmask    = (mask_len >= 8'h40) ? ones : ~(ones << mask_len);
    cmp_mask = (total >= 8'h40) ? ones : ~(ones << total);
    ref_val  = (mask & mmask) | ({60'h0, slot_index} << mask_len);
    hit      = ((uid ^ ref_val) & cmp_mask) == {UID_W{1'b0}};
  end
endmodule : isac_match

//--- rtl/isac_top.sv
// Inventory anticollision slot sequencer with APB control registers
`timescale 1ns/1ps
module isac_top
  import isac_pkg::*;
(
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  // APB slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // Link delimiters from the demodulator (async)
  input  wire logic                LINK_SOF,
  input  wire logic                LINK_EOF,
  // Decoded inventory request, valid with REQ_VALID
  input  wire logic                REQ_VALID,
  input  wire isac_pkg::isac_req_t REQ,
  // Reply launch to transmitter
  output isac_pkg::isac_reply_t    REPLY,
  output logic      [3:0]          SLOT_INDEX,
  output logic                     SEQ_ACTIVE
);
  import isac_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_SLOT  = 2'b10,
    ST_DONE  = 2'b11
  } isac_state_t;

  isac_state_t      state;
  isac_state_t      next_state;
  logic [3:0]       slot_index;
  logic [3:0]       next_slot_index;
  logic [4:0]       slot_total;
  logic [4:0]       next_slot_total;
  logic [2:0]       slot_index_width;
  logic [2:0]       next_slot_index_width;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             pend_req;
  logic             next_pend_req;
  isac_req_t        req;
  isac_req_t        next_req;
  isac_reply_t      reply;
  isac_reply_t      next_reply;
  logic [31:0]      ctrl;
  logic [31:0]      next_ctrl;
  logic [31:0]      uid_lo;
  logic [31:0]      next_uid_lo;
  logic [31:0]      uid_hi;
  logic [31:0]      next_uid_hi;
  logic [31:0]      prdata;
  logic [31:0]      next_prdata;
  logic             pready;
  logic             next_pready;
  logic             pslverr;
  logic             next_pslverr;
  logic [7:0]       slot_count;
  logic [7:0]       next_slot_count;
  logic             sof_rise;
  logic             eof_rise;
  logic             hit;

  // Delimiters cross in from the link
  isac_sync u_sof (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .din     (LINK_SOF),
    .dout    (),
    .rise    (sof_rise)
  );

  isac_sync u_eof (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .din     (LINK_EOF),
    .dout    (),
    .rise    (eof_rise)
  );

  isac_match u_match (
    .uid              ({uid_hi, uid_lo}),
    .mask             (req.mask),
    .mask_len         (req.mask_len),
    .slot_index       (slot_index),
    .slot_index_width (slot_index_width),
    .hit              (hit)
  );

  logic accept;
  logic apb_wr;
  logic apb_rd;

  always_comb begin
    accept = pend_req & ~ctrl[CTRL_QUIET] & ~req.crc_error;
    if (req.initiated && !ctrl[CTRL_ARMED]) begin
      accept = 1'b0;
    end
  end

  // Sequencer
  always_comb begin
    next_state            = state;
    next_slot_index       = slot_index;
    next_slot_total       = slot_total;
    next_slot_index_width = slot_index_width;
    next_cnt              = cnt;
    next_pend_req         = pend_req;
    next_req              = req;
    next_reply            = '0;
    next_reply.high_rate  = ctrl[CTRL_HIGH_RATE];
    next_reply.fast       = req.fast;
    next_slot_count       = slot_count;
    // family byte captured by front end when flagged
    if (REQ_VALID) begin
      next_req      = REQ;
      next_pend_req = 1'b1;
      if (!REQ.family_field_present) begin
        next_req.application_family_id = 8'h00;
      end
    end
    case (state)
      ST_IDLE: begin
        if (eof_rise && pend_req) begin
          next_pend_req = 1'b0;
          if (accept) begin
            next_slot_index = 4'h0;
            if (req.single_slot_select) begin
              next_slot_total       = 5'(SLOTS_SINGLE);
              next_slot_index_width = 3'h0;
            end else begin
              next_slot_total       = 5'(SLOTS_MULTI);
              next_slot_index_width = 3'(SLOT_W_MULTI);
            end
            next_cnt   = '0;
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // nominal count only, no upper-bound check
        if (sof_rise) begin
          next_state = ST_IDLE;
        end else if (cnt == CNT_W'(RESP_DELAY_CYC - 1)) begin
          next_reply.start = hit & ~req.crc_error;
          next_slot_count  = slot_count + 8'h01;
          next_state       = ST_SLOT;
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
      ST_SLOT: begin
        if (sof_rise) begin
          next_state = ST_IDLE;
        end else if (eof_rise) begin
          if ({1'b0, slot_index} < slot_total - 5'h01) begin
            next_slot_index = slot_index + 4'h1;
            next_cnt        = '0;
            next_state      = ST_WAIT;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (sof_rise) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_reply.high_rate = ctrl[CTRL_HIGH_RATE] | req.fast;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state            <= ST_IDLE;
      slot_index       <= 4'h0;
      slot_total       <= 5'h10;
      slot_index_width <= 3'h4;
      cnt              <= '0;
      pend_req         <= 1'b0;
      req              <= '0;
      reply            <= '0;
      slot_count       <= 8'h00;
    end else begin
      state            <= next_state;
      slot_index       <= next_slot_index;
      slot_total       <= next_slot_total;
      slot_index_width <= next_slot_index_width;
      cnt              <= next_cnt;
      pend_req         <= next_pend_req;
      req              <= next_req;
      reply            <= next_reply;
      slot_count       <= next_slot_count;
    end
  end

  // APB register file
  always_comb begin
    apb_wr       = PSEL & PENABLE & PWRITE;
    apb_rd       = PSEL & ~PENABLE & ~PWRITE;
    next_ctrl    = ctrl;
    next_uid_lo  = uid_lo;
    next_uid_hi  = uid_hi;
    next_prdata  = prdata;
    next_pready  = PSEL & ~PENABLE;
    next_pslverr = 1'b0;
    if (apb_wr && pready) begin
      case (PADDR)
        ADDR_CTRL:   next_ctrl   = PWDATA & 32'h00000007;
        ADDR_UID_LO: next_uid_lo = PWDATA;
        ADDR_UID_HI: next_uid_hi = PWDATA;
        default:     next_ctrl   = ctrl;
      endcase
    end
    if (PSEL && !PENABLE) begin
      case (PADDR)
        ADDR_CTRL:   next_prdata = ctrl;
        ADDR_STATUS: next_prdata = {16'h0000, slot_count, 2'h0, state, slot_index};
        ADDR_UID_LO: next_prdata = uid_lo;
        ADDR_UID_HI: next_prdata = uid_hi;
        ADDR_IDENT:  next_prdata = IDENT_VALUE;
        default:     next_prdata = 32'h00000000;
      endcase
      if (PADDR != ADDR_CTRL && PADDR != ADDR_STATUS && PADDR != ADDR_UID_LO &&
          PADDR != ADDR_UID_HI && PADDR != ADDR_IDENT) begin
        next_pslverr = 1'b1;
      end
      if (apb_rd) begin
        next_pready = 1'b1;
      end
    end else if (PSEL && PENABLE) begin
      next_pready = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl    <= CTRL_RESET;
      uid_lo  <= 32'h00000000;
      uid_hi  <= 32'h00000000;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      uid_lo  <= next_uid_lo;
      uid_hi  <= next_uid_hi;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  logic seq_active;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      seq_active <= 1'b0;
    end else begin
      seq_active <= (next_state == ST_WAIT) || (next_state == ST_SLOT);
    end
  end

  assign PRDATA     = prdata;
  assign PREADY     = pready;
  assign PSLVERR    = pslverr;
  assign REPLY      = reply;
  assign SLOT_INDEX = slot_index;
  assign SEQ_ACTIVE = seq_active;
endmodule : isac_top

//--- bench/isac_reader.sv
// Reader model: link delimiters and decoded requests
`timescale 1ns/1ps
module isac_reader
  import isac_pkg::*;
(
  // Tag clock
  input  wire logic          clk,
  // Link and request
  output logic               link_sof,
  output logic               link_eof,
  output logic               req_valid,
  output isac_pkg::isac_req_t req
);
  logic lclk = 1'b0;

  initial begin
    link_sof  = 1'b0;
    link_eof  = 1'b0;
    req_valid = 1'b0;
    req       = '0;
    forever #32 lclk = ~lclk;
  end

  task automatic send_sof();
    @(posedge lclk);
    link_sof <= 1'b1;
    @(posedge lclk);
    link_sof <= 1'b0;
  endtask : send_sof

  task automatic send_eof();
    @(posedge lclk);
    link_eof <= 1'b1;
    @(posedge lclk);
    link_eof <= 1'b0;
  endtask : send_eof

  // gap, then slot EOF
  // Gap is shortened to keep runs brief; the tag takes any EOF in a slot
  task automatic advance(input int gap);
    repeat (gap) @(posedge clk);
    send_eof();
  endtask : advance

  task automatic send_req(input isac_req_t r);
    isac_req_t q;
    q = r;
    q.mask = r.mask & ~({MASK_W{1'b1}} << r.mask_len);
    if (!r.family_field_present) begin
      q.application_family_id = 8'h00;
    end
    send_sof();
    @(posedge clk);
    req       <= q;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~q;
    send_eof();
  endtask : send_req
endmodule : isac_reader

//--- bench/isac_asserts.sv
// Checker for the slot sequencer ports
`timescale 1ns/1ps
module isac_asserts
  import isac_pkg::*;
(
  // Clock and reset
  input wire logic                  CLK,
  input wire logic                  SYS_RST,
  // APB side
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  // Link side
  input wire logic                  LINK_SOF,
  input wire logic                  LINK_EOF,
  input wire isac_pkg::isac_reply_t REPLY,
  input wire logic [3:0]            SLOT_INDEX,
  input wire logic                  SEQ_ACTIVE
);
  localparam int LO = RESP_DELAY_CYC - TOL_CYC;
  localparam int HI = RESP_DELAY_CYC + TOL_CYC;
  logic [CNT_W-1:0] age;
  logic [CNT_W-1:0] next_age;
  logic             eof_q;

  // Cycles since the last EOF pin rise
  always_comb begin
    next_age = age;
    if (LINK_EOF && !eof_q) begin
      next_age = '0;
    end else if (age != '1) begin
      next_age = age + 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      age   <= '1;
      eof_q <= 1'b0;
    end else begin
      age   <= next_age;
      eof_q <= LINK_EOF;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence done_s; PSEL && PENABLE && PREADY; endsequence

  apb_ready_a: assert property (setup_s |=> done_s) else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
  err_data_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("err data");
  reply_pulse_a: assert property (REPLY.start |=> !REPLY.start [*8]) else $error("reply held");
  reply_delay_a: assert property (REPLY.start |-> age >= LO && age <= HI) else $error("delay");
  sof_abort_a: assert property ($rose(LINK_SOF) |-> ##[1:8] !SEQ_ACTIVE) else $error("abort");
  seq_zero_a: assert property ($rose(SEQ_ACTIVE) |-> SLOT_INDEX == 4'h0) else $error("index");
  seq_start_a: assert property ($rose(SEQ_ACTIVE) |-> age <= 8) else $error("start");
  slot_step_a: assert property (SEQ_ACTIVE && $past(SEQ_ACTIVE) && $changed(SLOT_INDEX) |->
    SLOT_INDEX == $past(SLOT_INDEX) + 4'h1) else $error("step");
endmodule : isac_asserts

//--- bench/tb_inventory_slot_anticollision.sv
// Bench for the inventory slot sequencer
`timescale 1ns/1ps
module tb_inventory_slot_anticollision;
  import isac_pkg::*;
  logic        clk, rst, psel, pen, pwr, rdy, serr, sof, eof, rv, act, er;
  logic [7:0]  pa;
  logic [3:0]  slot;
  logic [31:0] pwd, prd, rd;
  isac_req_t   rq;
  isac_reply_t rep;
  int          fail_count, checks;

  isac_top dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr),
    .LINK_SOF(sof), .LINK_EOF(eof), .REQ_VALID(rv), .REQ(rq), .REPLY(rep),
    .SLOT_INDEX(slot), .SEQ_ACTIVE(act));
  isac_reader rdr (.clk(clk), .link_sof(sof), .link_eof(eof), .req_valid(rv), .req(rq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk32

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    chk32({31'h0, rdy}, 32'h1);
    if (rdy !== 1'b1) begin
      close_out();
    end
    rd = prd;
    er = serr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic want_act(input logic e);
    int n;
    n = 0;
    while (act !== e && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk32({31'h0, act}, {31'h0, e});
    if (act !== e) begin
      close_out();
    end
  endtask : want_act

  function automatic isac_req_t mk(input logic ini, input logic crc);
    isac_req_t r;
    r = '0;
    r.family_field_present  = 1'b1;
    r.application_family_id = 8'h3C;
    r.initiated = ini;
    r.fast      = ini;
    r.crc_error = crc;
    r.mask_len  = 8'h04;
    r.mask      = 64'hF5;
    return r;
  endfunction : mk

  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk32(rd, CTRL_RESET);
    apb(1'b0, 8'h40, 32'h0);
    chk32({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_UID_LO, 32'h12345605);
    apb(1'b1, ADDR_UID_HI, 32'h89ABCDEF);
    apb(1'b0, ADDR_UID_LO, 32'h0);
    chk32(rd, 32'h12345605);
    $display("regs done");
  endtask : t_regs

  task automatic t_refuse();
    apb(1'b1, ADDR_CTRL, 32'h3);
    rdr.send_req(mk(1'b0, 1'b0));
    want_act(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    rdr.send_req(mk(1'b0, 1'b1));
    want_act(1'b0);
    rdr.send_req(mk(1'b1, 1'b0));
    want_act(1'b0);
    $display("refuse done");
  endtask : t_refuse

  task automatic t_abort();
    rdr.send_req(mk(1'b0, 1'b0));
    want_act(1'b1);
    chk32({28'h0, slot}, 32'h0);
    rdr.send_sof();
    want_act(1'b0);
    rdr.send_req(mk(1'b0, 1'b0));
    want_act(1'b1);
    chk32({28'h0, slot}, 32'h0);
    $display("abort done");
  endtask : t_abort

  task automatic t_reply();
    int n;
    n = 0;
    apb(1'b1, ADDR_CTRL, 32'h5);
    fork
      rdr.send_req(mk(1'b1, 1'b0));
    join_none
    while (eof !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk32({31'h0, eof}, 32'h1);
    if (eof !== 1'b1) begin
      close_out();
    end
    n = 0;
    while (rep.start !== 1'b1 && n < 70000) begin
      @(posedge clk);
      n++;
    end
    chk32(n, RESP_DELAY_CYC + 3);
    if (rep.start !== 1'b1) begin
      close_out();
    end
    chk32({30'h0, rep.fast, rep.high_rate}, 32'h3);
    chk32({28'h0, slot}, 32'h0);
    rdr.advance(16);
    want_act(1'b1);
    chk32({28'h0, slot}, 32'h1);
    rdr.send_req(mk(1'b1, 1'b0));
    want_act(1'b1);
    chk32({28'h0, slot}, 32'h0);
    $display("reply done");
  endtask : t_reply

  initial begin
    fail_count = 0;
    checks     = 0;
    rst        = 1'b1;
    psel       = 1'b0;
    pen        = 1'b0;
    pwr        = 1'b0;
    pa         = 8'h00;
    pwd        = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_refuse();
    t_abort();
    t_reply();
    close_out();
  end
endmodule : tb_inventory_slot_anticollision

bind isac_top isac_asserts u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_SOF(LINK_SOF),
  .LINK_EOF(LINK_EOF), .REPLY(REPLY), .SLOT_INDEX(SLOT_INDEX), .SEQ_ACTIVE(SEQ_ACTIVE));
